// >>> common/tmc_pkg.sv
// Constants, field positions and types shared by the dual timer/counter block
package tmc_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_CTRL     = 8'h88;  // timer_control_flags
  localparam logic [7:0] IDX_MODE     = 8'h89;  // timer_mode_select
  localparam logic [7:0] IDX_A_LO     = 8'h8a;
  localparam logic [7:0] IDX_B_LO     = 8'h8b;
  localparam logic [7:0] IDX_A_HI     = 8'h8c;
  localparam logic [7:0] IDX_B_HI     = 8'h8d;
  localparam logic [7:0] IDX_CTRL2    = 8'h91;  // timer_control_second
  localparam logic [7:0] IDX_A_RLO    = 8'h92;
  localparam logic [7:0] IDX_B_RLO    = 8'h93;
  localparam logic [7:0] IDX_A_RHI    = 8'h94;
  localparam logic [7:0] IDX_B_RHI    = 8'h95;
  localparam logic [7:0] IDX_DIV      = 8'h96;  // shared_clock_divider
  localparam logic [7:0] IDX_SOFT     = 8'h97;  // software count inputs

  // Control register bit positions
  localparam int CTRL_TF_B  = 7;
  localparam int CTRL_RUN_B = 6;
  localparam int CTRL_TF_A  = 5;
  localparam int CTRL_RUN_A = 4;
  localparam int CTRL_IE_B  = 3;
  localparam int CTRL_IT_B  = 2;
  localparam int CTRL_IE_A  = 1;
  localparam int CTRL_IT_A  = 0;

  // Mode register bit positions
  localparam int MODE_GATE_B = 7;
  localparam int MODE_CT_B   = 6;
  localparam int MODE_M_B    = 4;
  localparam int MODE_GATE_A = 3;
  localparam int MODE_CT_A   = 2;
  localparam int MODE_M_A    = 0;

  // Software count register bit positions
  localparam int SOFT_PIN_A = 0;
  localparam int SOFT_PIN_B = 1;
  localparam int SOFT_SEL   = 2;

  // Reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [5:0] PSC_RST    = 6'h24;  // Both widths 100b, 5 active bits
  localparam logic [3:0] DIV_RST    = 4'h0;   // Divide by one
  localparam logic [2:0] SOFT_RST   = 3'h7;

  // Operating modes, in the order of the two mode bits
  typedef enum logic [1:0] {
    TMC_MODE_VAR,
    TMC_MODE_AR16,
    TMC_MODE_AR8,
    TMC_MODE_SPLIT
  } tmc_mode_t;

endpackage

// >>> common/tmc_tick_if.sv
// Shared prescale ratio and tick between the divider and the timer core
`timescale 1ns/100ps
interface tmc_tick_if;
  logic [3:0] div;   // Ratio minus one
  logic       tick;  // One-cycle enable
  modport src (input div, output tick);
  modport dst (output div, input tick);
endinterface // tmc_tick_if

// >>> rtl/tmc_div.sv
// Shared clock divider producing the timer tick enable
`timescale 1ns/100ps
module tmc_div (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Ratio in, tick out
  tmc_tick_if.src   tk
);

  logic [3:0] cnt_r;
  logic       at_end;

  // Tick on the last count of each period of div+1 cycles
  assign at_end  = (cnt_r >= tk.div);
  assign tk.tick = at_end;

  // Restart the period after the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= at_end ? 4'h0 : cnt_r + 4'h1;
    end
  end

endmodule // tmc_div

// >>> rtl/tmc_fall.sv
// Pin sampler with one-cycle falling transition detect
`timescale 1ns/100ps
module tmc_fall (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and results
  input  wire logic din,
  output logic      level,
  output logic      fall
);

  logic smp_r;
  logic prev_r;

  // Sample every cycle and keep the previous sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_r  <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      smp_r  <= din;
      prev_r <= smp_r;
    end
  end

  // High sample followed by a low sample
  assign level = smp_r;
  assign fall  = prev_r & ~smp_r;

endmodule // tmc_fall

// >>> rtl/tmc_top.sv
// Dual 16-bit timer/counter with four modes behind an APB register slave
//
// Contract
// - Timer ticks share one divider, ratio 1-16
// - Counter samples pin, counts high-then-low pairs
// - Incremented count visible one cycle after detect
// - Software bits may replace count pins
// - Function bit picks clock or pin
// - Two mode bits per unit select mode
// - Variable mode: 8-bit high, 1-8-bit prescaler
// - Default width thirteen bits, upper low ignored
// - Rollover to zero sets overflow flag
// - Count only when run and gate allow; split A high needs B run only
// - Run bit never clears the count
// - 16-bit mode reloads from pair, flags
// - Reload pairs reset to zero
// - 8-bit mode reloads low from high
// - Reload pair is free storage otherwise
// - Unit B in split mode holds count
// - Split: A high counts using B controls
// - B runs without its flag during split
// - Flags set on overflow, cleared on vectoring
// - External edge flags and type bits
// - Prescaler bits equal field plus one
`timescale 1ns/100ps
module tmc_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // External count and gate pins
  input  wire logic        count_pin_a,
  input  wire logic        count_pin_b,
  input  wire logic        gate_pin_a,
  input  wire logic        gate_pin_b,
  // Vectoring acknowledges from the interrupt controller
  input  wire logic        unit_a_vector_ack,
  input  wire logic        unit_b_vector_ack,
  input  wire logic        ext_a_vector_ack,
  input  wire logic        ext_b_vector_ack,
  // Flags and baud source
  output logic             unit_a_overflow_flag,
  output logic             unit_b_overflow_flag,
  output logic             ext_irq_a_edge_flag,
  output logic             ext_irq_b_edge_flag,
  output logic             unit_b_rollover
);

  // Count, reload and configuration storage
  logic [7:0] lo_a_r, hi_a_r, lo_b_r, hi_b_r;
  logic [7:0] rlo_a_r, rhi_a_r, rlo_b_r, rhi_b_r;
  logic [7:0] mode_r;
  logic [5:0] psc_r;
  logic [3:0] div_r;
  logic [2:0] soft_r;
  logic       tf_a_r, tf_b_r, run_a_r, run_b_r;
  logic       ie_a_r, ie_b_r, it_a_r, it_b_r;
  logic       roll_b_r;
  logic [31:0] prdata_r;

  // Next values
  logic [7:0] lo_a_nxt, hi_a_nxt, lo_b_nxt, hi_b_nxt;
  logic       tf_a_nxt, tf_b_nxt, ie_a_nxt, ie_b_nxt;

  // One counting step: returns {overflow, high, low}
  function automatic logic [16:0] tmc_step(input tmc_pkg::tmc_mode_t m,
                                           input logic [2:0] prescale_width_field,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo,
                                           input logic [7:0] rhi,
                                           input logic [7:0] rlo);
    logic [7:0] mask;
    logic [7:0] act;
    logic [16:0] res;
    mask = 8'hff >> (3'd7 - prescale_width_field);
    act  = lo & mask;
    res  = {1'b0, hi, lo};
    unique case (m)
      tmc_pkg::TMC_MODE_VAR: begin
        if (act == mask) begin
          // bits above the mask kept, not counted
          res = {(hi == 8'hff), hi + 8'h01, lo & ~mask};
        end else begin
          res = {1'b0, hi, (lo & ~mask) | ((act + 8'h01) & mask)};
        end
      end
      tmc_pkg::TMC_MODE_AR16: begin
        if ({hi, lo} == 16'hffff) begin
          res = {1'b1, rhi, rlo};
        end else begin
          res = {1'b0, {hi, lo} + 16'h0001};
        end
      end
      tmc_pkg::TMC_MODE_AR8: begin
        res = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      end
      // Split: only the low byte is stepped here
      tmc_pkg::TMC_MODE_SPLIT: begin
        res = {(lo == 8'hff), hi, lo + 8'h01};
      end
    endcase
    return res;
  endfunction

  // Shared divider through the tick interface
  tmc_tick_if tick_bus ();
  assign tick_bus.div = div_r;

  tmc_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (tick_bus.src)
  );

  // Mode decode
  tmc_pkg::tmc_mode_t mode_a;
  tmc_pkg::tmc_mode_t mode_b;
  assign mode_a = tmc_pkg::tmc_mode_t'(mode_r[tmc_pkg::MODE_M_A +: 2]);
  assign mode_b = tmc_pkg::tmc_mode_t'(mode_r[tmc_pkg::MODE_M_B +: 2]);

  // Count input selection
  logic cnt_in_a, cnt_in_b;
  // software bits stand in for pins
  assign cnt_in_a = soft_r[tmc_pkg::SOFT_SEL] ? soft_r[tmc_pkg::SOFT_PIN_A] : count_pin_a;
  assign cnt_in_b = soft_r[tmc_pkg::SOFT_SEL] ? soft_r[tmc_pkg::SOFT_PIN_B] : count_pin_b;

  // Pin samplers; a pulse shorter than a cycle may be missed
  logic cfall_a, cfall_b, gfall_a, gfall_b, glvl_a, glvl_b;

  tmc_fall u_cnt_a (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (cnt_in_a),
    .level   (),
    .fall    (cfall_a)
  );

  tmc_fall u_cnt_b (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (cnt_in_b),
    .level   (),
    .fall    (cfall_b)
  );

  tmc_fall u_gate_a (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (gate_pin_a),
    .level   (glvl_a),
    .fall    (gfall_a)
  );

  tmc_fall u_gate_b (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (gate_pin_b),
    .level   (glvl_b),
    .fall    (gfall_b)
  );

  // Count enables
  logic en_a, en_b, inc_a, inc_b, inc_ah, split_a;
  assign split_a = (mode_a == tmc_pkg::TMC_MODE_SPLIT);
  assign en_a = run_a_r & (~mode_r[tmc_pkg::MODE_GATE_A] | glvl_a);
  assign en_b = run_b_r & (~mode_r[tmc_pkg::MODE_GATE_B] | glvl_b)
              & (mode_b != tmc_pkg::TMC_MODE_SPLIT);
  assign inc_a = en_a & (mode_r[tmc_pkg::MODE_CT_A] ? cfall_a : tick_bus.tick);
  assign inc_b = en_b & (mode_r[tmc_pkg::MODE_CT_B] ? cfall_b : tick_bus.tick);
  // A high byte on B run
  assign inc_ah = split_a & run_b_r & tick_bus.tick;

  // Counting steps; reload pairs feed only the 16-bit mode
  logic [16:0] step_a, step_b;
  // pair read only by 16-bit mode
  assign step_a = tmc_step(mode_a, psc_r[2:0], hi_a_r, lo_a_r, rhi_a_r, rlo_a_r);
  assign step_b = tmc_step(mode_b, psc_r[5:3], hi_b_r, lo_b_r, rhi_b_r, rlo_b_r);

  // Overflow events
  logic set_tf_a, set_tf_b, ovf_b;
  assign set_tf_a = inc_a & step_a[16];
  assign ovf_b    = inc_b & step_b[16];
  // B loses its flag in split
  assign set_tf_b = split_a ? (inc_ah & (hi_a_r == 8'hff)) : ovf_b;

  // APB decode
  logic [7:0] idx;
  logic       acc, wr, setup, hit;
  logic [7:0] wb;
  logic [7:0] rd_byte;
  assign idx   = paddr[9:2];
  assign acc   = psel & penable;
  assign wr    = acc & pwrite;
  assign setup = psel & ~penable;
  assign wb    = pwdata[7:0];

  logic wr_ctrl, wr_mode, wr_lo_a, wr_lo_b, wr_hi_a, wr_hi_b;
  assign wr_ctrl = wr & (idx == tmc_pkg::IDX_CTRL);
  assign wr_mode = wr & (idx == tmc_pkg::IDX_MODE);
  assign wr_lo_a = wr & (idx == tmc_pkg::IDX_A_LO);
  assign wr_lo_b = wr & (idx == tmc_pkg::IDX_B_LO);
  assign wr_hi_a = wr & (idx == tmc_pkg::IDX_A_HI);
  assign wr_hi_b = wr & (idx == tmc_pkg::IDX_B_HI);

  // Read mux and address map
  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      tmc_pkg::IDX_CTRL:  rd_byte = {tf_b_r, run_b_r, tf_a_r, run_a_r,
                                     ie_b_r, it_b_r, ie_a_r, it_a_r};
      tmc_pkg::IDX_MODE:  rd_byte = mode_r;
      tmc_pkg::IDX_A_LO:  rd_byte = lo_a_r;
      tmc_pkg::IDX_B_LO:  rd_byte = lo_b_r;
      tmc_pkg::IDX_A_HI:  rd_byte = hi_a_r;
      tmc_pkg::IDX_B_HI:  rd_byte = hi_b_r;
      tmc_pkg::IDX_CTRL2: rd_byte = {2'b00, psc_r};
      tmc_pkg::IDX_A_RLO: rd_byte = rlo_a_r;
      tmc_pkg::IDX_B_RLO: rd_byte = rlo_b_r;
      tmc_pkg::IDX_A_RHI: rd_byte = rhi_a_r;
      tmc_pkg::IDX_B_RHI: rd_byte = rhi_b_r;
      tmc_pkg::IDX_DIV:   rd_byte = {4'h0, div_r};
      tmc_pkg::IDX_SOFT:  rd_byte = {5'h00, soft_r};
      default:            hit = 1'b0;
    endcase
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata  = prdata_r;

  // Next count values; a bus write to a byte wins over counting
  always_comb begin
    lo_a_nxt = inc_a ? step_a[7:0] : lo_a_r;
    lo_b_nxt = inc_b ? step_b[7:0] : lo_b_r;
    hi_b_nxt = inc_b ? step_b[15:8] : hi_b_r;
    if (split_a) begin
      hi_a_nxt = inc_ah ? hi_a_r + 8'h01 : hi_a_r;
    end else begin
      hi_a_nxt = inc_a ? step_a[15:8] : hi_a_r;
    end
    if (wr_lo_a) begin
      lo_a_nxt = wb;
    end
    if (wr_lo_b) begin
      lo_b_nxt = wb;
    end
    if (wr_hi_a) begin
      hi_a_nxt = wb;
    end
    if (wr_hi_b) begin
      hi_b_nxt = wb;
    end
  end

  // Flag next values
  always_comb begin
    tf_a_nxt = wr_ctrl ? wb[tmc_pkg::CTRL_TF_A] : tf_a_r & ~unit_a_vector_ack;
    tf_b_nxt = wr_ctrl ? wb[tmc_pkg::CTRL_TF_B] : tf_b_r & ~unit_b_vector_ack;
    tf_a_nxt = tf_a_nxt | set_tf_a;
    tf_b_nxt = tf_b_nxt | set_tf_b;
    if (it_a_r) begin
      ie_a_nxt = (wr_ctrl ? wb[tmc_pkg::CTRL_IE_A] : ie_a_r & ~ext_a_vector_ack) | gfall_a;
    end else begin
      ie_a_nxt = ~glvl_a;
    end
    if (it_b_r) begin
      ie_b_nxt = (wr_ctrl ? wb[tmc_pkg::CTRL_IE_B] : ie_b_r & ~ext_b_vector_ack) | gfall_b;
    end else begin
      ie_b_nxt = ~glvl_b;
    end
  end

  // count lands the cycle after detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_a_r <= tmc_pkg::COUNT_RST;
      hi_a_r <= tmc_pkg::COUNT_RST;
      lo_b_r <= tmc_pkg::COUNT_RST;
      hi_b_r <= tmc_pkg::COUNT_RST;
    end else begin
      lo_a_r <= lo_a_nxt;
      hi_a_r <= hi_a_nxt;
      lo_b_r <= lo_b_nxt;
      hi_b_r <= hi_b_nxt;
    end
  end

  // Control register; run bits touch only themselves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tf_b_r, run_b_r, tf_a_r, run_a_r} <= tmc_pkg::CTRL_RST[7:4];
      {ie_b_r, it_b_r, ie_a_r, it_a_r}   <= tmc_pkg::CTRL_RST[3:0];
    end else begin
      tf_a_r <= tf_a_nxt;
      tf_b_r <= tf_b_nxt;
      ie_a_r <= ie_a_nxt;
      ie_b_r <= ie_b_nxt;
      if (wr_ctrl) begin
        run_a_r <= wb[tmc_pkg::CTRL_RUN_A];
        run_b_r <= wb[tmc_pkg::CTRL_RUN_B];
        it_a_r  <= wb[tmc_pkg::CTRL_IT_A];
        it_b_r  <= wb[tmc_pkg::CTRL_IT_B];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rlo_a_r <= tmc_pkg::RELOAD_RST;
      rhi_a_r <= tmc_pkg::RELOAD_RST;
      rlo_b_r <= tmc_pkg::RELOAD_RST;
      rhi_b_r <= tmc_pkg::RELOAD_RST;
    end else if (wr) begin
      if (idx == tmc_pkg::IDX_A_RLO) rlo_a_r <= wb;
      if (idx == tmc_pkg::IDX_A_RHI) rhi_a_r <= wb;
      if (idx == tmc_pkg::IDX_B_RLO) rlo_b_r <= wb;
      if (idx == tmc_pkg::IDX_B_RHI) rhi_b_r <= wb;
    end
  end

  // Mode, prescale width, divider and software pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= tmc_pkg::MODE_RST;
      psc_r  <= tmc_pkg::PSC_RST;
      div_r  <= tmc_pkg::DIV_RST;
      soft_r <= tmc_pkg::SOFT_RST;
    end else begin
      if (wr_mode) mode_r <= wb;
      if (wr & (idx == tmc_pkg::IDX_CTRL2)) psc_r <= wb[5:0];
      if (wr & (idx == tmc_pkg::IDX_DIV)) div_r <= wb[3:0];
      if (wr & (idx == tmc_pkg::IDX_SOFT)) soft_r <= wb[2:0];
    end
  end

  // Read data captured in the setup phase; baud pulse registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      roll_b_r <= 1'b0;
    end else begin
      if (setup & ~pwrite) prdata_r <= {24'h00_0000, rd_byte};
      roll_b_r <= ovf_b;
    end
  end

  // Flag outputs straight from the registers
  assign unit_a_overflow_flag = tf_a_r;
  assign unit_b_overflow_flag = tf_b_r;
  assign ext_irq_a_edge_flag  = ie_a_r;
  assign ext_irq_b_edge_flag  = ie_b_r;
  assign unit_b_rollover      = roll_b_r;

endmodule // tmc_top

// >>> sim/tmc_top_monitor.sv
// Port-level assertions for the dual timer/counter register slave and flags
`timescale 1ns/100ps
module tmc_top_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Acknowledges and flags
  input wire logic        unit_a_vector_ack,
  input wire logic        unit_b_vector_ack,
  input wire logic        unit_a_overflow_flag,
  input wire logic        unit_b_overflow_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Own decode of the map, so refusals are judged independently
  wire logic [7:0] idx     = paddr[9:2];
  wire logic       mapped  = (idx >= 8'h88 && idx <= 8'h8d) || (idx >= 8'h91 && idx <= 8'h97);
  wire logic       ctrl_wr = psel && penable && pwrite && (idx == tmc_pkg::IDX_CTRL);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  a_ready_tied: assert property (pready) else $error("ready dropped");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("error outside access");
  a_err_map: assert property (s_access |-> pslverr == !mapped) else $error("error decode wrong");
  a_rdata_upper: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("rdata moved");
  a_unmap_zero: assert property (s_setup ##0 (!pwrite && !mapped) |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_flags: assert property (s_setup ##0 (!pwrite && idx == tmc_pkg::IDX_CTRL) |=>
    prdata[7] == $past(unit_b_overflow_flag) && prdata[5] == $past(unit_a_overflow_flag))
    else $error("flag readback wrong");
  a_flag_wr_set: assert property (ctrl_wr && pwdata[5] |=> unit_a_overflow_flag)
    else $error("flag write one lost");
  a_flag_a_hold: assert property ($fell(unit_a_overflow_flag) |-> $past(unit_a_vector_ack || ctrl_wr))
    else $error("flag a cleared alone");
  a_flag_b_hold: assert property ($fell(unit_b_overflow_flag) |-> $past(unit_b_vector_ack || ctrl_wr))
    else $error("flag b cleared alone");
endmodule // tmc_top_monitor

// >>> sim/tmc_pins_model.sv
// Outside source driving the count and gate pins
`timescale 1ns/100ps
module tmc_pins_model (
  // Clock
  input wire logic       pclk,
  // Commands from the bench
  input wire logic [1:0] req,
  input wire logic       slow,
  input wire logic [1:0] gate_level,
  // Pins
  output logic           count_pin_a,
  output logic           count_pin_b,
  output logic           gate_pin_a,
  output logic           gate_pin_b,
  output logic           busy
);
  logic [2:0] cnt_r  = 3'h0;
  logic [1:0] ch_r   = 2'h0;
  logic       slow_r = 1'b0;
  logic       low;

  // One high-low pair per request; slow stretches both levels
  always @(posedge pclk) begin
    if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
    else if (req != 2'h0) begin
      cnt_r  <= slow ? 3'h7 : 3'h3;
      ch_r   <= req;
      slow_r <= slow;
    end
  end
  assign low         = (cnt_r != 3'h0) && (cnt_r <= (slow_r ? 3'h4 : 3'h2));
  assign count_pin_a = !(low && ch_r[0]);  // Idle high, as with a pull-up
  assign count_pin_b = !(low && ch_r[1]);
  assign busy        = (cnt_r != 3'h0);
  // gating only as on the RC clock
  assign gate_pin_a  = gate_level[0];
  assign gate_pin_b  = gate_level[1];
endmodule // tmc_pins_model

// >>> sim/tb.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/100ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, busy, slow;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        cnt_a, cnt_b, gate_a, gate_b, roll;
  logic [1:0]  req, gl;
  logic [3:0]  ack, flags;
  logic [7:0]  v, w;
  logic [7:0]  ridx [9] = '{8'h88, 8'h89, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};
  logic [7:0]  rexp [9] = '{8'h00, 8'h00, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07};
  int          num_errors = 0, n_compared = 0, cyc = 0, t, n_roll = 0;

  tmc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_pin_a(cnt_a), .count_pin_b(cnt_b), .gate_pin_a(gate_a),
    .gate_pin_b(gate_b), .unit_a_vector_ack(ack[0]), .unit_b_vector_ack(ack[1]),
    .ext_a_vector_ack(ack[2]), .ext_b_vector_ack(ack[3]), .unit_a_overflow_flag(flags[0]),
    .unit_b_overflow_flag(flags[1]), .ext_irq_a_edge_flag(flags[2]),
    .ext_irq_b_edge_flag(flags[3]), .unit_b_rollover(roll));
  tmc_pins_model i_pins (.pclk(pclk), .req(req), .slow(slow), .gate_level(gl),
    .count_pin_a(cnt_a), .count_pin_b(cnt_b), .gate_pin_a(gate_a), .gate_pin_b(gate_b),
    .busy(busy));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    chk(q, {24'h0, exp});
  endtask
  task automatic pulse(input logic [1:0] r);
    @(posedge pclk);
    req <= r;
    slow <= 1'($urandom);
    @(posedge pclk);
    req <= 2'b00;
    repeat (2) @(posedge pclk);
    while (busy === 1'b1) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask
  task automatic ackp(input int i);
    @(posedge pclk);
    ack <= 4'h1 << i;
    @(posedge pclk);
    ack <= 4'h0;
    @(posedge pclk);
  endtask
  task automatic wait_flag(input int i);
    t = 0;
    while (flags[i] !== 1'b1 && t < 300) begin
      @(posedge pclk);
      t++;
    end
  endtask
  function automatic logic [7:0] lowmask(input logic [2:0] wd);
    return (8'h2 << wd) - 8'h1;
  endfunction
  task automatic print_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  // Baud pulses from unit B, counted to catch a stuck or missing pulse
  always @(posedge pclk) begin
    if (roll === 1'b1) n_roll <= n_roll + 1;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    req = 2'b00; slow = 1'b0; gl = 2'b11; ack = 4'h0; presetn = 1'b0;
    void'($urandom(32'h346e2153));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ridx[i]) rd(ridx[i], rexp[i]);
    apb(8'h00, 1'b0, 8'h00); chk({31'h0, err}, 1);  // Unmapped read refused
    chk(q, 0);
    apb(8'h98, 1'b1, 8'hff); chk({31'h0, err}, 1);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      apb(8'h92 + 8'(i), 1'b1, v); rd(8'h92 + 8'(i), v);
    end
    // Sixteen-bit reload, timer divided by sixteen
    v = 8'($urandom); w = 8'($urandom);
    apb(8'h96, 1'b1, 8'h0f); apb(8'h8a, 1'b1, 8'hfe); apb(8'h8c, 1'b1, 8'hff);
    apb(8'h92, 1'b1, w); apb(8'h94, 1'b1, v); apb(8'h89, 1'b1, 8'h01); apb(8'h88, 1'b1, 8'h10);
    wait_flag(0); chk({31'h0, t > 16 && t < 40}, 1);
    apb(8'h88, 1'b1, 8'h20);
    rd(8'h8a, w); rd(8'h8c, v);
    chk({31'h0, flags[0]}, 1);
    ackp(0); chk({31'h0, flags[0]}, 0);
    // Variable width with random prescaler width
    w = 8'($urandom_range(7, 0)); v = 8'($urandom) | lowmask(w[2:0]);
    apb(8'h91, 1'b1, w); apb(8'h8a, 1'b1, v); apb(8'h8c, 1'b1, 8'hff);
    apb(8'h89, 1'b1, 8'h00); apb(8'h88, 1'b1, 8'h10);
    wait_flag(0); chk({31'h0, t < 20}, 1);
    apb(8'h88, 1'b1, 8'h20);
    rd(8'h8a, v & ~lowmask(w[2:0])); rd(8'h8c, 8'h00);
    ackp(0);
    // Eight-bit reload counting falls on pin B
    v = 8'($urandom) & 8'h7f;
    apb(8'h97, 1'b1, 8'h00); apb(8'h8d, 1'b1, v); apb(8'h8b, 1'b1, 8'hfd);
    apb(8'h89, 1'b1, 8'h60); apb(8'h88, 1'b1, 8'h40);
    repeat (3) pulse(2'b10);
    chk({31'h0, flags[1]}, 1);
    chk(n_roll, 1);
    pulse(2'b10);
    rd(8'h8b, v + 8'h1); rd(8'h8d, v);
    apb(8'h89, 1'b1, 8'he0); gl <= 2'b01;
    pulse(2'b10); rd(8'h8b, v + 8'h1);
    chk({31'h0, flags[3]}, 1);
    gl <= 2'b11;
    pulse(2'b10); rd(8'h8b, v + 8'h2);
    chk({31'h0, flags[3]}, 0);
    // A read set up in the detect cycle still sees the old count
    apb(8'h97, 1'b1, 8'h06); apb(8'h97, 1'b1, 8'h04);
    rd(8'h8b, v + 8'h2);
    // One idle cycle later the new count must already stand
    apb(8'h97, 1'b1, 8'h06); apb(8'h97, 1'b1, 8'h04);
    @(posedge pclk);
    rd(8'h8b, v + 8'h4);
    ackp(1); chk({31'h0, flags[1]}, 0);
    // Split: A high runs on B controls, B holds
    apb(8'h88, 1'b1, 8'h00); apb(8'h89, 1'b1, 8'h33); apb(8'h8c, 1'b1, 8'hff);
    apb(8'h88, 1'b1, 8'h40);
    wait_flag(1); chk({31'h0, t < 40}, 1);
    apb(8'h88, 1'b1, 8'h80);
    rd(8'h8c, 8'h00); chk({31'h0, flags[0]}, 0);
    rd(8'h8b, v + 8'h4); rd(8'h8d, v);
    // External edge flag
    apb(8'h88, 1'b1, 8'h01); gl <= 2'b10;
    repeat (4) @(posedge pclk);
    chk({31'h0, flags[2]}, 1);
    gl <= 2'b11;
    ackp(2); chk({31'h0, flags[2]}, 0);
    chk(n_roll, 1);
    print_verdict();
  end
endmodule // tb

bind tmc_top tmc_top_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .unit_a_vector_ack(unit_a_vector_ack),
  .unit_b_vector_ack(unit_b_vector_ack), .unit_a_overflow_flag(unit_a_overflow_flag),
  .unit_b_overflow_flag(unit_b_overflow_flag));
